/* rtl/ccf_pkg.sv */
// Constants and types for the controller capability fields block
package ccf_pkg;
    // Byte offsets of the fields inside the identify structure
    localparam logic [11:0] OCS_OFFSET = 12'h208;
    localparam logic [11:0] FOS_OFFSET = 12'h20a;
    localparam logic [11:0] FA_OFFSET = 12'h20c;
    localparam int unsigned FIELD_BYTES = 5;
    localparam logic [2:0] LAST_IDX = 3'h4;
    // Optional command support bit positions
    localparam int unsigned OCS_COMPARE_BIT = 0;
    localparam int unsigned OCS_WRUNC_BIT = 1;
    localparam int unsigned OCS_DSM_BIT = 2;
    localparam int unsigned OCS_WZ_BIT = 3;
    localparam int unsigned OCS_SAVESEL_BIT = 4;
    localparam int unsigned OCS_RESV_BIT = 5;
    localparam int unsigned OCS_TSTAMP_BIT = 6;
    localparam int unsigned OCS_VERIFY_BIT = 7;
    // Fused operation support and format attribute bit positions
    localparam int unsigned FOS_CMPWR_BIT = 0;
    localparam int unsigned FA_ALL_FMT_BIT = 0;
    localparam int unsigned FA_ALL_ERASE_BIT = 1;
    localparam int unsigned FA_CRYPTO_BIT = 2;
    // Reserved masks, these bits always read as zero
    localparam logic [15:0] OCS_RSVD_MASK = 16'hff00;
    localparam logic [15:0] FOS_RSVD_MASK = 16'hfffe;
    localparam logic [7:0] FA_RSVD_MASK = 8'hf8;
    localparam logic [7:0] RD_RESET = 8'h00;
    // Read latency from request to answer, in cycles
    localparam int unsigned RD_LATENCY = 2;

    typedef enum logic [3:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_COMPARE,
        CMD_WRITE_UNC,
        CMD_DSM,
        CMD_WRITE_ZEROES,
        CMD_VERIFY,
        CMD_RESV_REGISTER,
        CMD_RESV_REPORT,
        CMD_RESV_ACQUIRE,
        CMD_RESV_RELEASE,
        CMD_SET_FEATURES,
        CMD_GET_FEATURES,
        CMD_TIMESTAMP,
        CMD_FORMAT
    } ccf_cmd_t;

    typedef enum logic [1:0] {
        FUSE_NONE,
        FUSE_FIRST,
        FUSE_SECOND
    } ccf_fuse_t;

    typedef enum logic [1:0] {
        ERASE_NONE,
        ERASE_USER,
        ERASE_CRYPTO
    } ccf_erase_t;

    typedef enum logic [1:0] {
        ST_OK,
        ST_BAD_OPCODE,
        ST_BAD_FIELD,
        ST_FUSE_FAIL
    } ccf_status_t;
endpackage

/* rtl/ccf_rom_if.sv */
// Read port between the capability block and its field store
`timescale 1ns/1ns
interface ccf_rom_if;
    logic rd_en;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;

    modport user
    (
        output rd_en,
        output rd_idx,
        input rd_data
    );

    modport rom
    (
        input rd_en,
        input rd_idx,
        output rd_data
    );
endinterface

/* rtl/ccf_rom.sv */
// Constant byte store for the capability fields, registered read data
`timescale 1ns/1ns
module ccf_rom #(
    parameter logic [39:0] CONTENT = 40'h0
)
(
    input wire logic clk,
    input wire logic sys_rst,
    ccf_rom_if.rom bus
);
    typedef struct packed {
        logic [7:0] data;
    } ccf_rom_state_t;

    ccf_rom_state_t st_ff;
    ccf_rom_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (bus.rd_en)
        begin
            if (bus.rd_idx <= ccf_pkg::LAST_IDX)
            begin
                nxt_st.data = CONTENT[{bus.rd_idx, 3'h0} +: 8];
            end
            else
            begin
                nxt_st.data = ccf_pkg::RD_RESET;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign bus.rd_data = st_ff.data;
endmodule

/* rtl/ccf_top.sv */
// Controller capability fields: identify byte reads and command gating
// What this block does
// - Optional command support bits 15 to 8 read as zero.
// - Bit 7 set only when Verify is implemented.
// - Bit 6 set only when the timestamp feature is implemented.
// - Bit 5 set means all four reservation commands are accepted.
// - Bit 4 governs non-zero save and select fields in feature commands.
// - Bit 3 set only when Write Zeroes is implemented.
// - Bit 2 set only when Dataset Management is implemented.
// - Bit 1 set only when Write Uncorrectable is implemented.
// - Bit 0 set only when Compare is implemented.
// - Fused operation support bits 15 to 1 read as zero.
// - Fused bit 0 set only when compare-then-write fusing is implemented.
// - Format attribute bits 7 to 3 read as zero.
// - Format bit 2 set only when cryptographic erase is supported.
// - Format bit 1 picks subsystem-wide or single-namespace secure erase.
// - Format bit 0 set means one format formats every namespace.
// - Format bit 0 clear means per-namespace format is supported.
`timescale 1ns/1ns
module ccf_top #(
    parameter int unsigned ADDR_W = 12,
    parameter bit SUP_COMPARE = 1'b1,
    parameter bit SUP_WRITE_UNC = 1'b1,
    parameter bit SUP_DSM = 1'b1,
    parameter bit SUP_WRITE_ZEROES = 1'b1,
    parameter bit SUP_SAVE_SELECT = 1'b1,
    parameter bit SUP_RESERVATIONS = 1'b1,
    parameter bit SUP_TIMESTAMP = 1'b1,
    parameter bit SUP_VERIFY = 1'b1,
    parameter bit SUP_FUSED_CMPWR = 1'b1,
    parameter bit SUP_ALL_NS_FORMAT = 1'b0,
    parameter bit SUP_ALL_NS_ERASE = 1'b0,
    parameter bit SUP_CRYPTO_ERASE = 1'b1
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic rd_valid,
    output logic rd_hit,
    output logic [7:0] rd_data,
    input wire logic chk_valid,
    input wire ccf_pkg::ccf_cmd_t chk_cmd,
    input wire ccf_pkg::ccf_fuse_t chk_fuse,
    input wire logic chk_field_nz,
    input wire ccf_pkg::ccf_erase_t chk_erase,
    output logic chk_done,
    output ccf_pkg::ccf_status_t chk_status,
    output logic fmt_all_ns,
    output logic erase_all_ns,
    output logic fuse_pending
);
    // Address must reach the last field byte
    if (ADDR_W < 10 || ADDR_W > 16)
    begin : g_addr_w_check
        $error("ADDR_W must be 10 to 16");
    end

    // Fixed field values, reserved bits held at zero
    // fixed word
    localparam logic [15:0] OCS_VALUE = ~ccf_pkg::OCS_RSVD_MASK &
        {8'h00, SUP_VERIFY, SUP_TIMESTAMP, SUP_RESERVATIONS, SUP_SAVE_SELECT,
         SUP_WRITE_ZEROES, SUP_DSM, SUP_WRITE_UNC, SUP_COMPARE};
    localparam logic [15:0] FOS_VALUE = ~ccf_pkg::FOS_RSVD_MASK &
        {15'h0000, SUP_FUSED_CMPWR};
    localparam logic [7:0] FA_VALUE = ~ccf_pkg::FA_RSVD_MASK &
        {5'h00, SUP_CRYPTO_ERASE, SUP_ALL_NS_ERASE, SUP_ALL_NS_FORMAT};
    localparam logic [39:0] ROM_CONTENT = {FA_VALUE, FOS_VALUE, OCS_VALUE};

    typedef struct packed {
        logic p1_valid;
        logic p1_hit;
        logic [2:0] p1_idx;
        logic rd_valid;
        logic rd_hit;
        logic [2:0] rd_idx;
        logic [7:0] rd_data;
        logic chk_done;
        ccf_pkg::ccf_status_t chk_status;
        logic fmt_all_ns;
        logic erase_all_ns;
        logic fuse_pending;
    } ccf_state_t;

    ccf_state_t st_ff;
    ccf_state_t nxt_st;
    ccf_rom_if rom_bus();
    logic [15:0] addr_ext;
    logic [15:0] addr_off;
    logic addr_hit;

    ccf_rom #(
        .CONTENT(ROM_CONTENT)
    ) ccf_rom_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus(rom_bus)
    );

    // Whether a command class is implemented at all
    function automatic logic cmd_supported(input ccf_pkg::ccf_cmd_t cmd);
        logic sup;
        sup = 1'b0;
        case (cmd)
            ccf_pkg::CMD_COMPARE: sup = SUP_COMPARE;
            ccf_pkg::CMD_WRITE_UNC: sup = SUP_WRITE_UNC;
            ccf_pkg::CMD_DSM: sup = SUP_DSM;
            ccf_pkg::CMD_WRITE_ZEROES: sup = SUP_WRITE_ZEROES;
            ccf_pkg::CMD_VERIFY: sup = SUP_VERIFY;
            ccf_pkg::CMD_TIMESTAMP: sup = SUP_TIMESTAMP;
            ccf_pkg::CMD_RESV_REGISTER,
            ccf_pkg::CMD_RESV_REPORT,
            ccf_pkg::CMD_RESV_ACQUIRE,
            ccf_pkg::CMD_RESV_RELEASE: sup = SUP_RESERVATIONS;
            default: sup = 1'b1;
        endcase
        return sup;
    endfunction

    assign addr_ext = 16'(rd_addr);
    assign addr_off = addr_ext - 16'(ccf_pkg::OCS_OFFSET);
    assign addr_hit = addr_ext >= 16'(ccf_pkg::OCS_OFFSET) &&
        addr_ext <= 16'(ccf_pkg::FA_OFFSET);
    assign rom_bus.rd_en = rd_req && addr_hit;
    assign rom_bus.rd_idx = addr_off[2:0];

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.p1_valid = rd_req;
        nxt_st.p1_hit = addr_hit;
        nxt_st.p1_idx = addr_off[2:0];
        nxt_st.rd_valid = st_ff.p1_valid;
        if (st_ff.p1_valid)
        begin
            nxt_st.rd_hit = st_ff.p1_hit;
            nxt_st.rd_idx = st_ff.p1_idx;
            nxt_st.rd_data = st_ff.p1_hit ? rom_bus.rd_data : ccf_pkg::RD_RESET;
        end
        nxt_st.chk_done = chk_valid;
        if (chk_valid)
        begin
            nxt_st.chk_status = ccf_pkg::ST_OK;
            if (!cmd_supported(chk_cmd))
            begin
                nxt_st.chk_status = ccf_pkg::ST_BAD_OPCODE;
            end
            else if ((chk_cmd == ccf_pkg::CMD_SET_FEATURES ||
                      chk_cmd == ccf_pkg::CMD_GET_FEATURES) &&
                     chk_field_nz && !SUP_SAVE_SELECT)
            begin
                nxt_st.chk_status = ccf_pkg::ST_BAD_FIELD;
            end
            else if (chk_cmd == ccf_pkg::CMD_FORMAT &&
                     chk_erase == ccf_pkg::ERASE_CRYPTO && !SUP_CRYPTO_ERASE)
            begin
                nxt_st.chk_status = ccf_pkg::ST_BAD_FIELD;
            end
            case (chk_fuse)
                ccf_pkg::FUSE_FIRST:
                begin
                    nxt_st.fuse_pending = SUP_FUSED_CMPWR &&
                        chk_cmd == ccf_pkg::CMD_COMPARE && !st_ff.fuse_pending;
                    if (!nxt_st.fuse_pending)
                    begin
                        nxt_st.chk_status = ccf_pkg::ST_FUSE_FAIL;
                    end
                end
                ccf_pkg::FUSE_SECOND:
                begin
                    nxt_st.fuse_pending = 1'b0;
                    if (!st_ff.fuse_pending || chk_cmd != ccf_pkg::CMD_WRITE)
                    begin
                        nxt_st.chk_status = ccf_pkg::ST_FUSE_FAIL;
                    end
                end
                default:
                begin
                    nxt_st.fuse_pending = 1'b0;
                    if (st_ff.fuse_pending)
                    begin
                        nxt_st.chk_status = ccf_pkg::ST_FUSE_FAIL;
                    end
                end
            endcase
            if (chk_cmd == ccf_pkg::CMD_FORMAT)
            begin
                nxt_st.fmt_all_ns = SUP_ALL_NS_FORMAT;
                nxt_st.erase_all_ns = SUP_ALL_NS_ERASE &&
                    chk_erase != ccf_pkg::ERASE_NONE;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rd_valid = st_ff.rd_valid;
    assign rd_hit = st_ff.rd_hit;
    assign rd_data = st_ff.rd_data;
    assign chk_done = st_ff.chk_done;
    assign chk_status = st_ff.chk_status;
    assign fmt_all_ns = st_ff.fmt_all_ns;
    assign erase_all_ns = st_ff.erase_all_ns;
    assign fuse_pending = st_ff.fuse_pending;

    ocs_rsvd_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        st_ff.rd_valid && st_ff.rd_hit && st_ff.rd_idx == 3'h1 |-> st_ff.rd_data == 8'h00)
        else $error("reserved command support bits not zero");

    ocs_low_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_req && addr_ext == 16'(ccf_pkg::OCS_OFFSET) |-> ##2
        rd_valid && rd_hit && rd_data == OCS_VALUE[7:0] && rd_data[7] == SUP_VERIFY)
        else $error("command support low byte wrong");

    fos_rsvd_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        st_ff.rd_valid && st_ff.rd_hit && st_ff.rd_idx inside {3'h2, 3'h3} |->
        st_ff.rd_data[7:1] == 7'h00 && (st_ff.rd_idx == 3'h2 || st_ff.rd_data == 8'h00))
        else $error("reserved fused bits not zero");

    fa_rsvd_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_req && addr_ext == 16'(ccf_pkg::FA_OFFSET) |-> ##2
        rd_valid && rd_data[7:3] == 5'h00 && rd_data[2] == SUP_CRYPTO_ERASE)
        else $error("format attribute byte wrong");

    rd_stable_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_req ##1 rd_req && rd_addr == $past(rd_addr) |-> ##2
        rd_valid && rd_data == $past(rd_data))
        else $error("field value changed between reads");

    resv_gate_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        chk_valid && chk_fuse == ccf_pkg::FUSE_NONE && !fuse_pending &&
        chk_cmd inside {ccf_pkg::CMD_RESV_REGISTER, ccf_pkg::CMD_RESV_REPORT,
            ccf_pkg::CMD_RESV_ACQUIRE, ccf_pkg::CMD_RESV_RELEASE} |=>
        chk_done && chk_status == (SUP_RESERVATIONS ? ccf_pkg::ST_OK : ccf_pkg::ST_BAD_OPCODE))
        else $error("reservation command gating wrong");

    save_sel_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        chk_valid && chk_cmd inside {ccf_pkg::CMD_SET_FEATURES, ccf_pkg::CMD_GET_FEATURES} &&
        chk_field_nz && chk_fuse == ccf_pkg::FUSE_NONE && !fuse_pending && !SUP_SAVE_SELECT
        |=> chk_status == ccf_pkg::ST_BAD_FIELD)
        else $error("non-zero save field not refused");

    fuse_order_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        chk_valid && chk_fuse == ccf_pkg::FUSE_SECOND && chk_cmd != ccf_pkg::CMD_WRITE
        |=> chk_status == ccf_pkg::ST_FUSE_FAIL && !fuse_pending)
        else $error("fused second command not write accepted");

    fuse_pair_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        chk_valid && chk_fuse == ccf_pkg::FUSE_FIRST && chk_cmd == ccf_pkg::CMD_COMPARE &&
        !fuse_pending |=> fuse_pending == SUP_FUSED_CMPWR)
        else $error("fused first command handling wrong");

    fmt_scope_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        chk_valid && chk_cmd == ccf_pkg::CMD_FORMAT |=>
        fmt_all_ns == SUP_ALL_NS_FORMAT &&
        erase_all_ns == (SUP_ALL_NS_ERASE && $past(chk_erase) != ccf_pkg::ERASE_NONE))
        else $error("format scope wrong");

    crypto_gate_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        chk_valid && chk_cmd == ccf_pkg::CMD_FORMAT && chk_erase == ccf_pkg::ERASE_CRYPTO &&
        chk_fuse == ccf_pkg::FUSE_NONE && !fuse_pending |=>
        chk_status == (SUP_CRYPTO_ERASE ? ccf_pkg::ST_OK : ccf_pkg::ST_BAD_FIELD))
        else $error("crypto erase gating wrong");

    rd_answer_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_req |-> ##2 rd_valid && rd_hit == $past(addr_hit, 2))
        else $error("read answer missing or misplaced");
endmodule

/* tb/ccf_top_tb.sv */
// Self-checking testbench for the controller capability fields block
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        check_count++; \
        if ((got) !== (ex)) \
        begin \
            miscompares++; \
            $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
        end \
    end
module ccf_top_tb;
    localparam bit P_CMP = 1'b1, P_WU = 1'b1, P_DSM = 1'b0, P_WZ = 1'b1, P_SS = 1'b0;
    localparam bit P_RESV = 1'b0, P_TS = 1'b1, P_VER = 1'b0, P_FUSED = 1'b1;
    localparam bit P_FMT = 1'b1, P_ERS = 1'b1, P_CRY = 1'b0;
    localparam logic [15:0] EXP_OCS = {8'h00, P_VER, P_TS, P_RESV, P_SS, P_WZ, P_DSM, P_WU, P_CMP};
    localparam logic [15:0] EXP_FOS = {15'h0000, P_FUSED};
    localparam logic [7:0] EXP_FA = {5'h00, P_CRY, P_ERS, P_FMT};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rd_req = 1'b0;
    logic [11:0] rd_addr = 12'h000;
    logic rd_valid, rd_hit, chk_done, fmt_all_ns, erase_all_ns, fuse_pending;
    logic [7:0] rd_data;
    logic chk_valid = 1'b0;
    logic chk_field_nz = 1'b0;
    ccf_pkg::ccf_cmd_t chk_cmd = ccf_pkg::CMD_READ;
    ccf_pkg::ccf_fuse_t chk_fuse = ccf_pkg::FUSE_NONE;
    ccf_pkg::ccf_erase_t chk_erase = ccf_pkg::ERASE_NONE;
    ccf_pkg::ccf_status_t chk_status;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [8:0] rq[$];
    logic [5:0] cq[$];

    always #2 clk = ~clk;

    ccf_top #(.ADDR_W(12), .SUP_COMPARE(P_CMP), .SUP_WRITE_UNC(P_WU), .SUP_DSM(P_DSM),
        .SUP_WRITE_ZEROES(P_WZ), .SUP_SAVE_SELECT(P_SS), .SUP_RESERVATIONS(P_RESV),
        .SUP_TIMESTAMP(P_TS), .SUP_VERIFY(P_VER), .SUP_FUSED_CMPWR(P_FUSED),
        .SUP_ALL_NS_FORMAT(P_FMT), .SUP_ALL_NS_ERASE(P_ERS), .SUP_CRYPTO_ERASE(P_CRY))
    ccf_top_i (.clk(clk), .sys_rst(sys_rst), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_data(rd_data), .chk_valid(chk_valid),
        .chk_cmd(chk_cmd), .chk_fuse(chk_fuse), .chk_field_nz(chk_field_nz),
        .chk_erase(chk_erase), .chk_done(chk_done), .chk_status(chk_status),
        .fmt_all_ns(fmt_all_ns), .erase_all_ns(erase_all_ns), .fuse_pending(fuse_pending));

    function automatic logic [7:0] exp_byte(input logic [11:0] a);
        case (a)
            12'h208: return EXP_OCS[7:0];
            12'h209: return EXP_OCS[15:8];
            12'h20a: return EXP_FOS[7:0];
            12'h20b: return EXP_FOS[15:8];
            12'h20c: return EXP_FA;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic sup(input ccf_pkg::ccf_cmd_t c);
        case (c)
            ccf_pkg::CMD_COMPARE: return P_CMP;
            ccf_pkg::CMD_WRITE_UNC: return P_WU;
            ccf_pkg::CMD_DSM: return P_DSM;
            ccf_pkg::CMD_WRITE_ZEROES: return P_WZ;
            ccf_pkg::CMD_VERIFY: return P_VER;
            ccf_pkg::CMD_TIMESTAMP: return P_TS;
            ccf_pkg::CMD_RESV_REGISTER, ccf_pkg::CMD_RESV_REPORT: return P_RESV;
            ccf_pkg::CMD_RESV_ACQUIRE, ccf_pkg::CMD_RESV_RELEASE: return P_RESV;
            default: return 1'b1;
        endcase
    endfunction

    // Answers are matched in order, whatever the latency
    always @(posedge clk)
    begin
        if (rd_valid === 1'b1)
        begin
            `CHK("read answer expected", 1'b1, rq.size() > 0)
            if (rq.size() > 0)
            begin
                `CHK("rd_hit", rq[0][8], rd_hit)
                `CHK("rd_data", rq[0][7:0], rd_data)
                void'(rq.pop_front());
            end
        end
        if (chk_done === 1'b1)
        begin
            `CHK("check answer expected", 1'b1, cq.size() > 0)
            if (cq.size() > 0)
            begin
                `CHK("chk_status", cq[0][1:0], chk_status)
                `CHK("fuse_pending", cq[0][2], fuse_pending)
                if (cq[0][5])
                begin
                    `CHK("fmt_all_ns", cq[0][3], fmt_all_ns)
                    `CHK("erase_all_ns", cq[0][4], erase_all_ns)
                end
                void'(cq.pop_front());
            end
        end
    end

    task automatic end_sim;
        $display("Checks %0d, miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            end_sim();
        end
    end

    task automatic drain;
        int n;
        n = 0;
        rd_req = 1'b0;
        chk_valid = 1'b0;
        while ((rq.size() + cq.size()) > 0 && n < 10)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("answers outstanding", 0, rq.size() + cq.size())
    endtask

    task automatic rd(input logic [11:0] a);
        rd_req = 1'b1;
        rd_addr = a;
        rq.push_back({a inside {[12'h208:12'h20c]}, exp_byte(a)});
        @(posedge clk);
        #1;
    endtask

    task automatic ck(input ccf_pkg::ccf_cmd_t c, input ccf_pkg::ccf_fuse_t f, input logic nz,
                      input ccf_pkg::ccf_erase_t e, input ccf_pkg::ccf_status_t st,
                      input logic pend, input logic fe);
        chk_valid = 1'b1;
        chk_cmd = c;
        chk_fuse = f;
        chk_field_nz = nz;
        chk_erase = e;
        cq.push_back({fe, P_ERS && e != ccf_pkg::ERASE_NONE, P_FMT, pend, st});
        @(posedge clk);
        #1;
    endtask

    task automatic t_reset;
        `CHK("rd_valid idle", 1'b0, rd_valid)
        `CHK("chk_done idle", 1'b0, chk_done)
        `CHK("fuse_pending idle", 1'b0, fuse_pending)
        `CHK("status idle", ccf_pkg::ST_OK, chk_status)
        `CHK("rd_hit idle", 1'b0, rd_hit)
        `CHK("rd_data idle", 8'h00, rd_data)
        `CHK("fmt_all_ns idle", 1'b0, fmt_all_ns)
        `CHK("erase_all_ns idle", 1'b0, erase_all_ns)
    endtask

    task automatic t_fields;
        for (int a = 12'h206; a <= 12'h20e; a++) rd(12'(a));
        rd(12'hfff);
        rd(12'h000);
        for (int a = 12'h20c; a >= 12'h208; a--) rd(12'(a));
        rd(12'h208);
        drain();
    endtask

    task automatic t_classes;
        ccf_pkg::ccf_cmd_t c;
        for (int i = 0; i <= 14; i++)
        begin
            c = ccf_pkg::ccf_cmd_t'(i);
            ck(c, ccf_pkg::FUSE_NONE, 1'b0, ccf_pkg::ERASE_USER,
               sup(c) ? ccf_pkg::ST_OK : ccf_pkg::ST_BAD_OPCODE, 1'b0,
               c == ccf_pkg::CMD_FORMAT);
        end
        drain();
    endtask

    task automatic t_features;
        ccf_pkg::ccf_status_t nzst;
        nzst = P_SS ? ccf_pkg::ST_OK : ccf_pkg::ST_BAD_FIELD;
        ck(ccf_pkg::CMD_SET_FEATURES, ccf_pkg::FUSE_NONE, 1'b1, ccf_pkg::ERASE_NONE, nzst,
           1'b0, 1'b0);
        ck(ccf_pkg::CMD_GET_FEATURES, ccf_pkg::FUSE_NONE, 1'b1, ccf_pkg::ERASE_NONE, nzst,
           1'b0, 1'b0);
        ck(ccf_pkg::CMD_GET_FEATURES, ccf_pkg::FUSE_NONE, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_OK, 1'b0, 1'b0);
        drain();
    endtask

    task automatic t_format;
        ck(ccf_pkg::CMD_FORMAT, ccf_pkg::FUSE_NONE, 1'b0, ccf_pkg::ERASE_CRYPTO,
           P_CRY ? ccf_pkg::ST_OK : ccf_pkg::ST_BAD_FIELD, 1'b0, 1'b0);
        ck(ccf_pkg::CMD_FORMAT, ccf_pkg::FUSE_NONE, 1'b0, ccf_pkg::ERASE_USER,
           ccf_pkg::ST_OK, 1'b0, 1'b1);
        ck(ccf_pkg::CMD_FORMAT, ccf_pkg::FUSE_NONE, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_OK, 1'b0, 1'b1);
        ck(ccf_pkg::CMD_FORMAT, ccf_pkg::FUSE_NONE, 1'b0, ccf_pkg::ERASE_USER,
           ccf_pkg::ST_OK, 1'b0, 1'b1);
        drain();
    endtask

    // Reset in mid-run clears held results
    task automatic t_midreset;
        `CHK("erase_all_ns held", P_ERS, erase_all_ns)
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        t_reset();
        sys_rst = 1'b0;
    endtask

    task automatic t_fused;
        ck(ccf_pkg::CMD_COMPARE, ccf_pkg::FUSE_FIRST, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_OK, 1'b1, 1'b0);
        ck(ccf_pkg::CMD_WRITE, ccf_pkg::FUSE_SECOND, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_OK, 1'b0, 1'b0);
        ck(ccf_pkg::CMD_WRITE, ccf_pkg::FUSE_FIRST, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_FUSE_FAIL, 1'b0, 1'b0);
        ck(ccf_pkg::CMD_WRITE, ccf_pkg::FUSE_SECOND, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_FUSE_FAIL, 1'b0, 1'b0);
        ck(ccf_pkg::CMD_COMPARE, ccf_pkg::FUSE_FIRST, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_OK, 1'b1, 1'b0);
        ck(ccf_pkg::CMD_READ, ccf_pkg::FUSE_NONE, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_FUSE_FAIL, 1'b0, 1'b0);
        ck(ccf_pkg::CMD_COMPARE, ccf_pkg::FUSE_FIRST, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_OK, 1'b1, 1'b0);
        ck(ccf_pkg::CMD_COMPARE, ccf_pkg::FUSE_FIRST, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_FUSE_FAIL, 1'b0, 1'b0);
        ck(ccf_pkg::CMD_COMPARE, ccf_pkg::FUSE_FIRST, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_OK, 1'b1, 1'b0);
        ck(ccf_pkg::CMD_COMPARE, ccf_pkg::FUSE_SECOND, 1'b0, ccf_pkg::ERASE_NONE,
           ccf_pkg::ST_FUSE_FAIL, 1'b0, 1'b0);
        drain();
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_fields();
        t_classes();
        t_features();
        t_format();
        t_midreset();
        t_fused();
        t_fields();
        end_sim();
    end
endmodule
